//--- slem_err_counter.sv
// one saturating or wrapping error counter with threshold detection
// assumes inc and clr are single-cycle strobes on ref_clk
`timescale 1ns/1ps
`default_nettype none
module slem_err_counter #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic inc,
  input wire logic clr,
  input wire logic hold,
  input wire logic [W-1:0] thresh,
  output logic [W-1:0] count,
  output logic reached
);
  import slem_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
  } slem_cnt_state_t;

  slem_cnt_state_t s_q, s_d;
  logic inc_eff;

  // hold stops at all ones; reached ignores clr to keep the reinit path loop free
  always_comb begin
    s_d = s_q;
    inc_eff = inc && !(hold && s_q.cnt == '1); // [RQ23]
    if (clr) begin
      s_d.cnt = '0; // [RQ24] [RQ14]
    end else if (inc_eff) begin
      s_d.cnt = W'(s_q.cnt + 1'b1); // [RQ23]
    end
    reached = inc_eff && (W'(s_q.cnt + 1'b1) == thresh);
    count = s_q.cnt;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  hold_saturates_a: assert property (hold && inc && !clr && count == '1 |=> count == '1) // [RQ23]
    else $error("held counter left all ones");
  wrap_to_zero_a: assert property (!hold && inc && !clr && count == '1 |=> count == '0) // [RQ23]
    else $error("counter did not wrap to zero");
  clear_zero_a: assert property (clr |=> count == '0 && $past(count) >= 0) // [RQ24]
    else $error("counter not cleared");
endmodule
`default_nettype wire

//--- slem_link_monitor.sv
// link error monitor: apb register file, error counters, irq status, sync request
// assumes lane events come from the 8b/10b decoder, synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module slem_link_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire slem_pkg::slem_apb_req_t apb_req,
  output var slem_pkg::slem_apb_rsp_t apb_rsp,
  input wire slem_pkg::slem_lane_evt_t [7:0] lane_evt,
  input wire logic [7:0] lane_active,
  input wire logic deskew_fail,
  input wire logic [13:0][7:0] rx_params,
  output logic sync_request_out_n,
  output logic link_reinit
);
  import slem_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
    logic cks_mode;
    logic [3:0] pulse_len;
    logic [7:0] thresh;
    logic [2:0] mask;
    logic [7:0][5:0] lane_ctl;
    logic [7:0][2:0] hold;
    logic [13:0][7:0] cfg;
    logic [7:0] irq_en;
    logic irq_en_mm;
    logic [7:0] irq_st;
    logic irq_st_mm;
    logic [7:0] cgs;
    logic [7:0] fsync;
    logic [7:0] align;
    logic [7:0] cks_ok;
    logic [7:0][2:0] disp_cnt;
  } slem_mon_state_t;

  localparam slem_mon_state_t ST_RST = '{
    thresh: THRESH_RST, mask: MASK_RST, lane_ctl: {8{LANE_CTL_RST}},
    irq_en: IRQ_EN_RST, irq_en_mm: IRQ_EN_MM_RST, pulse_len: PULSE_RST,
    default: '0};

  slem_mon_state_t s_q, s_d;
  logic [7:0][2:0][7:0] cnt;
  logic [7:0][2:0] reached;
  logic [7:0][2:0] err_in;
  logic [7:0][2:0] sw_clr;
  logic [11:0] idx;
  logic wr;
  logic hit;
  logic [31:0] rd_val;
  logic [7:0] evt;
  logic [2:0] over;
  logic any_err;
  logic reinit;
  logic mismatch;
  logic [7:0] disp_hit;

  // ----------------------------------------------------------------
  // checksum over the received link parameters
  // ----------------------------------------------------------------
  function automatic logic [7:0] calc_cks(input logic mode, input logic [13:0][7:0] p,
                                          input logic [4:0] lid);
    logic [7:0] sum;
    sum = 8'h00;
    if (mode) begin
      for (int i = 0; i <= 12; i++) begin
        sum = 8'(sum + p[i]); // [RQ18]
      end
      sum = 8'(sum + {3'h0, lid});
    end else begin
      // did, bid, lid, scr, l, f, k, m, n, subclass, np, jesdv, s, hd
      sum = 8'(p[0] + {4'h0, p[1][3:0]} + {3'h0, lid} + {7'h00, p[3][7]}
            + {3'h0, p[3][4:0]} + p[4] + {3'h0, p[5][4:0]} + p[6]
            + {3'h0, p[7][4:0]} + {5'h00, p[8][7:5]} + {3'h0, p[8][4:0]}
            + {5'h00, p[9][7:5]} + {3'h0, p[9][4:0]} + {7'h00, p[10][7]}); // [RQ17]
    end
    return sum;
  endfunction

  // ----------------------------------------------------------------
  // error counters, one per lane and type
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_LANES * 3; g++) begin : g_cnt
    localparam int L = g / 3;
    localparam int T = g % 3;
    slem_err_counter #(.W(8)) u_cnt (
      .ref_clk(ref_clk),
      .rst(rst),
      .inc(err_in[L][T]),
      .clr(sw_clr[L][T] || reinit),
      .hold(s_q.hold[L][T]),
      .thresh(s_q.thresh),
      .count(cnt[L][T]),
      .reached(reached[L][T])
    );
  end

  // ----------------------------------------------------------------
  // sync request and reinitialization
  // ----------------------------------------------------------------
  slem_sync_gen u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .err_evt(any_err),
    .reinit(reinit),
    .pulse_len(s_q.pulse_len),
    .f_minus1(s_q.cfg[CFG_F_BYTE]),
    .sync_request_out_n(sync_request_out_n),
    .reinit_busy(link_reinit)
  );

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  // type order in every 3-bit group: 0 disparity, 1 not in table, 2 control char
  always_comb begin
    over = '0;
    disp_hit = '0;
    for (int l = 0; l < NUM_LANES; l++) begin
      err_in[l][0] = lane_evt[l].bde && s_q.lane_ctl[l][CTL_MON_LSB + 0]; // [RQ11]
      err_in[l][1] = lane_evt[l].not_in_table_error && s_q.lane_ctl[l][CTL_MON_LSB + 1];
      err_in[l][2] = lane_evt[l].unexpected_control_char_error && s_q.lane_ctl[l][CTL_MON_LSB + 2];
      disp_hit[l] = lane_evt[l].bde && s_q.disp_cnt[l] == DISP_REINIT_LAST; // [RQ9]
      over = over | reached[l];
    end
    any_err = |err_in; // [RQ6]
    reinit = (|disp_hit) || (|(over & s_q.mask)); // [RQ9] [RQ12] [RQ13]
    mismatch = (s_q.cfg != rx_params); // [RQ22]
    evt = '0;
    evt[IRQ_OVER_LSB +: 3] = {over[2], over[1], over[0]}; // [RQ1]
    evt[IRQ_DESKEW] = deskew_fail;
    for (int l = 0; l < NUM_LANES; l++) begin
      evt[IRQ_CGS] = evt[IRQ_CGS] | (s_q.cgs[l] && !lane_evt[l].cgs);
      evt[IRQ_FSYNC] = evt[IRQ_FSYNC] | (s_q.fsync[l] && !lane_evt[l].fsync);
      evt[IRQ_ALIGN] = evt[IRQ_ALIGN] | (s_q.align[l] && !lane_evt[l].align);
      evt[IRQ_CKS] = evt[IRQ_CKS] | (lane_evt[l].cks_stb
        && lane_evt[l].cks_rx != calc_cks(s_q.cks_mode, rx_params, lane_evt[l].lid));
    end
  end

  // ----------------------------------------------------------------
  // register read decode
  // ----------------------------------------------------------------
  // misaligned addresses and holes answer with pslverr; the unused fourth counter slot of each lane reads zero without it
  always_comb begin
    idx = apb_req.paddr[13:2];
    rd_val = '0;
    hit = (apb_req.paddr[1:0] == 2'h0);
    if (idx == IDX_CKS_MODE) begin
      rd_val[CKS_MODE_BIT] = s_q.cks_mode;
    end else if (idx == IDX_PULSE) begin
      rd_val[PULSE_LSB +: 4] = s_q.pulse_len;
    end else if (idx >= IDX_RXP_BASE && idx <= IDX_RXP_LAST) begin
      rd_val[7:0] = rx_params[4'(idx - IDX_RXP_BASE)];
    end else if (idx >= IDX_CFG_BASE && idx <= IDX_CFG_LAST) begin
      rd_val[7:0] = s_q.cfg[4'(idx - IDX_CFG_BASE)];
    end else if (idx == IDX_CGS) begin
      rd_val[7:0] = s_q.cgs; // [RQ15]
    end else if (idx == IDX_FSYNC) begin
      rd_val[7:0] = s_q.fsync; // [RQ16]
    end else if (idx == IDX_CKS_OK) begin
      rd_val[7:0] = s_q.cks_ok; // [RQ17]
    end else if (idx == IDX_ALIGN) begin
      rd_val[7:0] = s_q.align; // [RQ19]
    end else if (idx == IDX_THRESH) begin
      rd_val[7:0] = s_q.thresh;
    end else if (idx == IDX_MASK) begin
      rd_val[2:0] = s_q.mask;
    end else if (idx[11:3] == IDX_LANE_CTL[11:3]) begin
      rd_val[5:0] = s_q.lane_ctl[idx[2:0]];
    end else if (idx[11:3] == IDX_LANE_HOLD[11:3]) begin
      rd_val[2:0] = s_q.hold[idx[2:0]];
    end else if (idx[11:3] == IDX_LANE_TERM[11:3]) begin
      for (int t = 0; t < 3; t++) begin
        rd_val[t] = (cnt[idx[2:0]][t] == 8'hff);
      end
      rd_val[TERM_ACTIVE_BIT] = lane_active[idx[2:0]];
    end else if (idx[11:5] == IDX_ERR_CNT[11:5]) begin
      rd_val[7:0] = (idx[1:0] == 2'h3) ? 8'h00 : cnt[idx[4:2]][idx[1:0]];
    end else if (idx == IDX_IRQ_EN) begin
      rd_val[7:0] = s_q.irq_en;
    end else if (idx == IDX_IRQ_EN_MM) begin
      rd_val[0] = s_q.irq_en_mm;
    end else if (idx == IDX_IRQ_ST) begin
      rd_val[7:0] = s_q.irq_st; // [RQ4]
    end else if (idx == IDX_IRQ_ST_MM) begin
      rd_val[0] = s_q.irq_st_mm; // [RQ4]
    end else begin
      hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // next state: apb handshake, register writes, status capture
  // ----------------------------------------------------------------
  // one wait state so that prdata leaves a flip-flop
  always_comb begin
    s_d = s_q;
    sw_clr = '0;
    wr = apb_req.psel && apb_req.penable && apb_req.pwrite && s_q.ack && !s_q.err;
    if (apb_req.psel && apb_req.penable && !s_q.ack) begin
      s_d.ack = 1'b1;
      s_d.err = !hit;
      s_d.rdata = apb_req.pwrite ? 32'h0000_0000 : rd_val;
    end else begin
      s_d.ack = 1'b0;
      s_d.err = 1'b0;
    end
    if (wr) begin
      if (idx == IDX_CKS_MODE) begin
        s_d.cks_mode = apb_req.pwdata[CKS_MODE_BIT]; // [RQ18]
      end else if (idx == IDX_PULSE) begin
        s_d.pulse_len = apb_req.pwdata[PULSE_LSB +: 4]; // [RQ8]
      end else if (idx >= IDX_CFG_BASE && idx <= IDX_CFG_LAST) begin
        s_d.cfg[4'(idx - IDX_CFG_BASE)] = apb_req.pwdata[7:0];
      end else if (idx == IDX_THRESH) begin
        s_d.thresh = apb_req.pwdata[7:0]; // [RQ25]
      end else if (idx == IDX_MASK) begin
        s_d.mask = apb_req.pwdata[2:0]; // [RQ12]
      end else if (idx[11:3] == IDX_LANE_CTL[11:3]) begin
        s_d.lane_ctl[idx[2:0]] = apb_req.pwdata[5:0]; // [RQ11]
        sw_clr[idx[2:0]] = ~apb_req.pwdata[2:0]; // [RQ24]
      end else if (idx[11:3] == IDX_LANE_HOLD[11:3]) begin
        s_d.hold[idx[2:0]] = apb_req.pwdata[2:0]; // [RQ23]
      end else if (idx == IDX_IRQ_EN) begin
        s_d.irq_en = apb_req.pwdata[7:0]; // [RQ1] [RQ2] [RQ3]
      end else if (idx == IDX_IRQ_EN_MM) begin
        s_d.irq_en_mm = apb_req.pwdata[0]; // [RQ2] [RQ21]
      end else if (idx == IDX_IRQ_ST) begin
        s_d.irq_st = s_q.irq_st & ~apb_req.pwdata[7:0]; // [RQ20] [RQ26]
      end else if (idx == IDX_IRQ_ST_MM) begin
        s_d.irq_st_mm = s_q.irq_st_mm & ~apb_req.pwdata[0]; // [RQ21]
      end
    end
    // new events override a clear in the same cycle; reinit leaves status alone
    s_d.irq_st = s_d.irq_st | (s_q.irq_en & evt); // [RQ4] [RQ14]
    s_d.irq_st_mm = s_d.irq_st_mm | (s_q.irq_en_mm && mismatch); // [RQ22]
    for (int l = 0; l < NUM_LANES; l++) begin
      s_d.cgs[l] = lane_evt[l].cgs; // [RQ15]
      s_d.fsync[l] = lane_evt[l].fsync; // [RQ16]
      s_d.align[l] = lane_evt[l].align; // [RQ19]
      if (lane_evt[l].cks_stb) begin
        s_d.cks_ok[l] = (lane_evt[l].cks_rx
          == calc_cks(s_q.cks_mode, rx_params, lane_evt[l].lid)); // [RQ17] [RQ18]
      end
      if (reinit) begin
        s_d.disp_cnt[l] = 3'h0; // [RQ14]
      end else if (lane_evt[l].bde) begin
        s_d.disp_cnt[l] = 3'(s_q.disp_cnt[l] + 3'h1); // [RQ9]
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // response fields straight from flip-flops
  always_comb begin
    apb_rsp.prdata = s_q.rdata;
    apb_rsp.pready = s_q.ack;
    apb_rsp.pslverr = s_q.ack && s_q.err;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  en_reset_zero_a: assert property ($fell(rst) |-> s_q.irq_en == 8'h00 // [RQ3]
      && s_q.irq_en_mm && s_q.thresh == 8'hff)
    else $error("enable or threshold reset value wrong");
  set_wins_a: assert property (wr && idx == IDX_IRQ_ST && (s_q.irq_en & evt) != 8'h00 // [RQ20]
      |=> (s_q.irq_st & $past(s_q.irq_en & evt)) == $past(s_q.irq_en & evt))
    else $error("event lost against a status clear");
  w1c_clear_a: assert property (wr && idx == IDX_IRQ_ST && (s_q.irq_en & evt) == 8'h00 // [RQ26]
      |=> (s_q.irq_st & $past(apb_req.pwdata[7:0])) == 8'h00)
    else $error("status bit survived write one to clear");
  mismatch_flag_a: assert property (s_q.irq_en_mm && s_q.cfg != rx_params // [RQ22]
      |=> s_q.irq_st_mm)
    else $error("mismatch status not raised");
  thresh_sync_a: assert property ((|(over & s_q.mask)) |=> ##[0:1] !sync_request_out_n) // [RQ13]
    else $error("threshold reach did not request sync");
  status_kept_a: assert property (reinit && !wr |=> s_q.irq_st >= $past(s_q.irq_st) // [RQ14]
      && (s_q.irq_st & $past(s_q.irq_st)) == $past(s_q.irq_st))
    else $error("reinit disturbed irq status");
  four_disp_a: assert property (lane_evt[0].bde [*4] ##0 !wr |=> link_reinit) // [RQ9]
    else $error("four disparity errors without reinit");

  cover_err_pulse_c: cover property (any_err ##1 !sync_request_out_n);
  cover_thresh_c: cover property (|over ##1 s_q.irq_st[7:5] != 3'h0);
  cover_w1c_c: cover property (wr && idx == IDX_IRQ_ST ##1 s_q.irq_st == 8'h00);
endmodule
`default_nettype wire

//--- slem_pkg.sv
// Function
// [RQ1] over-threshold irq enables for three error types sit in bits 7:5 at 0x4b8
// [RQ2] bring-up irq enables in bits 4:0 at 0x4b8, mismatch enable in bit 0 at 0x4b9
// [RQ3] enables at 0x4b8 reset to zero and act only once software writes one
// [RQ4] status bits at 0x4ba and 0x4bb mirror the enable bit positions
// [RQ5] software enables irqs before link bring-up, then clears and monitors them
// [RQ6] any monitored character error pulses the active-low sync request
// [RQ7] error pulse width is programmable to half, one or two link clocks; code 0 gives one clock here, never half
// [RQ8] pulse length field bits 7:4 of 0x312, default 0, picks the pulse width
// [RQ9] four invalid-disparity characters on a lane force link reinitialization
// [RQ10] reinitialization holds sync request low five frames plus nine octets
// [RQ11] per-lane monitor enables in lane register bits 5:3 reset to enabled
// [RQ12] mask at 0x47d enables threshold sync per type: uek, nit, disparity
// [RQ13] masked type counter reaching threshold at 0x47c drives sync request low
// [RQ14] reinitialization clears all counters but never the interrupt status
// [RQ15] code group lock bit per lane set after commas and code group sync
// [RQ16] frame lock bit per lane set after initial frame synchronization
// [RQ17] checksum ok bit per lane when ilas checksum equals sum of link fields
// [RQ18] with mode bit set checksum is sum of received bytes plus lane id
// [RQ19] lane alignment bit per lane set after alignment sequence passes
// [RQ20] writing one to status bits 3:0 clears those bring-up events
// [RQ21] mismatch enable defaults on; its status bit is cleared by writing one
// [RQ22] mismatch flag raised when local and received link parameters differ
// [RQ23] with hold option counter stops at 0xff, otherwise wraps to zero
// [RQ24] writing zero to a lane counter reset bit clears that counter
// [RQ25] shared threshold defaults to 0xff and serves every type and lane
// [RQ26] writing one to status bits 7:5 clears the over-threshold events
//
// package of the link error monitor: register indices, fields, reset values
// assumes an apb master with 32-bit data; register byte address is index * 4
package slem_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam int NUM_LANES = 8;
  localparam int NUM_PARAMS = 14;
  localparam logic [11:0] IDX_CKS_MODE = 12'h300;
  localparam logic [11:0] IDX_PULSE = 12'h312;
  localparam logic [11:0] IDX_RXP_BASE = 12'h400;
  localparam logic [11:0] IDX_RXP_LAST = 12'h40d;
  localparam logic [11:0] IDX_CFG_BASE = 12'h450;
  localparam logic [11:0] IDX_CFG_LAST = 12'h45d;
  localparam logic [11:0] IDX_CGS = 12'h470;
  localparam logic [11:0] IDX_FSYNC = 12'h471;
  localparam logic [11:0] IDX_CKS_OK = 12'h472;
  localparam logic [11:0] IDX_ALIGN = 12'h473;
  localparam logic [11:0] IDX_THRESH = 12'h47c;
  localparam logic [11:0] IDX_MASK = 12'h47d;
  localparam logic [11:0] IDX_LANE_CTL = 12'h480;
  localparam logic [11:0] IDX_LANE_HOLD = 12'h488;
  localparam logic [11:0] IDX_LANE_TERM = 12'h490;
  localparam logic [11:0] IDX_ERR_CNT = 12'h4c0;
  localparam logic [11:0] IDX_IRQ_EN = 12'h4b8;
  localparam logic [11:0] IDX_IRQ_EN_MM = 12'h4b9;
  localparam logic [11:0] IDX_IRQ_ST = 12'h4ba;
  localparam logic [11:0] IDX_IRQ_ST_MM = 12'h4bb;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CKS_MODE_BIT = 6;
  localparam int PULSE_LSB = 4;
  localparam int CTL_MON_LSB = 3;
  localparam int TERM_ACTIVE_BIT = 3;
  localparam int CFG_F_BYTE = 4;
  localparam int IRQ_CGS = 0;
  localparam int IRQ_FSYNC = 1;
  localparam int IRQ_CKS = 2;
  localparam int IRQ_ALIGN = 3;
  localparam int IRQ_DESKEW = 4;
  localparam int IRQ_OVER_LSB = 5;
  localparam logic [7:0] THRESH_RST = 8'hff;
  localparam logic [2:0] MASK_RST = 3'h7;
  localparam logic [5:0] LANE_CTL_RST = 6'h3f;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic IRQ_EN_MM_RST = 1'b1;
  localparam logic [3:0] PULSE_RST = 4'h0;

  // ----------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------
  localparam int REINIT_FRAMES = 5;
  localparam int REINIT_OCTETS = 9;
  localparam int OCTETS_PER_PCLK = 4;
  localparam logic [2:0] DISP_REINIT_LAST = 3'h3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cgs;
    logic fsync;
    logic align;
    logic bde;
    logic not_in_table_error;
    logic unexpected_control_char_error;
    logic cks_stb;
    logic [7:0] cks_rx;
    logic [4:0] lid;
  } slem_lane_evt_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [13:0] paddr;
    logic [31:0] pwdata;
  } slem_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } slem_apb_rsp_t;

endpackage

//--- slem_sync_gen.sv
// sync request generator: error pulse and reinitialization hold
// assumes err_evt and reinit are single-cycle strobes on ref_clk
`timescale 1ns/1ps
`default_nettype none
module slem_sync_gen (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic err_evt,
  input wire logic reinit,
  input wire logic [3:0] pulse_len,
  input wire logic [7:0] f_minus1,
  output logic sync_request_out_n,
  output logic reinit_busy
);
  import slem_pkg::*;

  typedef struct packed {
    logic [10:0] cnt;
    logic busy;
    logic sync_n;
  } slem_sync_state_t;

  slem_sync_state_t s_q, s_d;
  logic [10:0] reinit_cycles;
  logic [10:0] pulse_cycles;

  // five frames plus nine octets, rounded up to whole link clocks
  always_comb begin
    reinit_cycles = 11'((REINIT_FRAMES * (int'(f_minus1) + 1) + REINIT_OCTETS
                    + OCTETS_PER_PCLK - 1) / OCTETS_PER_PCLK); // [RQ10]
    // a half clock cannot be made on one edge, so code 0 stretches to one clock
    pulse_cycles = (pulse_len >= 4'h2) ? 11'h002 : 11'h001; // [RQ7] [RQ8]
    s_d = s_q;
    if (s_q.cnt != 11'h000) begin
      s_d.cnt = s_q.cnt - 11'h001;
    end
    if (reinit) begin
      s_d.cnt = reinit_cycles; // [RQ10]
      s_d.busy = 1'b1;
    end else if (err_evt && !s_q.busy && s_d.cnt < pulse_cycles) begin
      s_d.cnt = pulse_cycles; // [RQ6]
    end
    if (s_d.cnt == 11'h000) begin
      s_d.busy = 1'b0;
    end
    s_d.sync_n = (s_d.cnt == 11'h000);
    sync_request_out_n = s_q.sync_n;
    reinit_busy = s_q.busy;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{sync_n: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  reinit_hold_len_a: assert property ((reinit && f_minus1 == 8'h00) // [RQ10]
      ##1 (!reinit && !err_evt)[*4] |=> sync_request_out_n)
    else $error("reinit hold not four clocks for one-octet frames");
  reinit_low_a: assert property (reinit |=> !sync_request_out_n [*3]) // [RQ10]
    else $error("sync request not held low after reinit");
  err_pulse_two_a: assert property (err_evt && pulse_len == 4'h2 && !reinit // [RQ7]
      && !reinit_busy && sync_request_out_n |=> !sync_request_out_n ##1 !sync_request_out_n)
    else $error("two clock error pulse too short");
  cover_reinit_c: cover property (reinit ##1 !sync_request_out_n);
endmodule
`default_nettype wire

//--- slem_tx_model.sv
// transmitter stand-in: lane lock levels, one-cycle error strobes per lane
// assumes the bench drives go just after an edge; n cycles of go give n strobes
`timescale 1ns/1ps
`default_nettype none
module slem_tx_model (
  input wire logic ref_clk,
  input wire logic [2:0] lane,
  input wire logic [2:0] kind,
  input wire logic go,
  input wire logic [7:0] lock_n,
  output var slem_pkg::slem_lane_evt_t [7:0] lane_evt
);
  import slem_pkg::*;
  // lock levels follow lock_n; a strobe lasts exactly one cycle
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 8; i++) begin
      lane_evt[i] <= '0;
      lane_evt[i].cgs <= !lock_n[i];
      lane_evt[i].fsync <= !lock_n[i];
      lane_evt[i].align <= !lock_n[i];
      lane_evt[i].bde <= go && lane == i && kind[0];
      lane_evt[i].not_in_table_error <= go && lane == i && kind[1];
      lane_evt[i].unexpected_control_char_error <= go && lane == i && kind[2];
      // kind zero sends the ilas checksum, correct for all-zero parameters
      lane_evt[i].cks_stb <= go && lane == i && kind == 3'h0;
      lane_evt[i].cks_rx <= 8'(i);
      lane_evt[i].lid <= 5'(i);
    end
  end
endmodule
`default_nettype wire

//--- tb.sv
// self-checking bench of the link error monitor over apb
// assumes one apb wait state as handed over; reads checked from a queue
`timescale 1ns/1ps
`default_nettype none
module tb;
  import slem_pkg::*;
  logic ref_clk = 0, rst = 1, go = 0, dsk = 0;
  logic [2:0] lane = 0, kind = 0, l2;
  logic [7:0] lock_n = 0;
  logic [31:0] seed = 32'h73c4;
  logic [13:0][7:0] rxp = '0;
  slem_apb_req_t req = '0;
  slem_apb_rsp_t rsp;
  slem_lane_evt_t [7:0] evt;
  logic sync_n, reinit;
  logic [32:0] expq[$];
  int err_total = 0, n_compared = 0;
  always #12.5 ref_clk = !ref_clk;
  slem_tx_model u_tx (.ref_clk(ref_clk), .lane(lane), .kind(kind), .go(go), .lock_n(lock_n),
    .lane_evt(evt));
  slem_link_monitor u_dut (.ref_clk(ref_clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .lane_evt(evt), .lane_active(8'hff), .deskew_fail(dsk), .rx_params(rxp),
    .sync_request_out_n(sync_n), .link_reinit(reinit));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    n_compared++;
    if (seen !== want) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // one apb transfer; an idle edge after release keeps drives one per step
  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
    req <= '{1'b1, 1'b0, w, {idx, 2'b00}, {24'h0, d}};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do @(posedge ref_clk); while (rsp.pready !== 1'b1);
    req <= '0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [11:0] idx, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, idx, 8'h00);
  endtask
  // hold go for n cycles: n back-to-back strobes of kind k on lane l
  task automatic burst(input logic [2:0] l, input logic [2:0] k, input int n);
    lane <= l;
    kind <= k;
    go <= 1'b1;
    repeat (n) @(posedge ref_clk);
    go <= 1'b0;
  endtask
  // strobe one error, then expect n low cycles of sync with reinit flag r
  task automatic hit(input logic [2:0] l, input logic [2:0] k, input int n, input logic r);
    burst(l, k, 1);
    repeat (2) @(posedge ref_clk);
    repeat (n) begin
      chk({sync_n, reinit}, {1'b0, r});
      @(posedge ref_clk);
    end
    chk({sync_n, reinit}, 2'b10);
  endtask
  // read answers are compared against the oldest noted value
  always @(posedge ref_clk) begin
    if (rsp.pready === 1'b1 && req.pwrite === 1'b0 && expq.size() > 0) begin
      chk({rsp.pslverr, rsp.prdata}, expq.pop_front());
    end
  end
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // a hang costs far more than the few hundred cycles the tests need
  initial begin
    #50us;
    err_total++;
    print_verdict();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(IDX_THRESH, 33'hff);
    rd(IDX_MASK, 33'h7);
    rd(IDX_LANE_CTL + 7, 33'h3f);
    rd(IDX_IRQ_EN, 33'h0);
    rd(IDX_IRQ_EN_MM, 33'h1);
    rd(IDX_PULSE, 33'h0);
    rd(12'h7ff, {1'b1, 32'h0});
    apb(1'b1, IDX_IRQ_EN, 8'hff);
    lock_n <= 8'h04;
    dsk <= 1'b1;
    @(posedge ref_clk);
    dsk <= 1'b0;
    rd(IDX_CGS, 33'hfb);
    rd(IDX_FSYNC, 33'hfb);
    rd(IDX_ALIGN, 33'hfb);
    rd(IDX_IRQ_ST, 33'h1b);
    apb(1'b1, IDX_IRQ_ST, 8'h01);
    rd(IDX_IRQ_ST, 33'h1a);
    rd(IDX_LANE_TERM, 33'h8);
    burst(3'h3, 3'h0, 1);
    rd(IDX_CKS_OK, 33'h08);
    apb(1'b1, IDX_CKS_MODE, 8'h40);
    burst(3'h4, 3'h0, 1);
    rd(IDX_CKS_OK, 33'h18);
    seed = xs(seed);
    l2 = seed[2:0] ^ 3'h1;
    hit(seed[2:0], 3'b010, 1, 1'b0);
    apb(1'b1, IDX_PULSE, 8'h20);
    hit(seed[5:3], 3'b100, 2, 1'b0);
    apb(1'b1, IDX_THRESH, 8'h02);
    apb(1'b1, IDX_MASK, 8'h02);
    hit(l2, 3'b010, 2, 1'b0);
    hit(l2, 3'b010, 4, 1'b1);
    rd(IDX_IRQ_ST, 33'h5a);
    rd(IDX_ERR_CNT + {l2, 2'b01}, 33'h0);
    apb(1'b1, IDX_IRQ_ST, 8'hff);
    rd(IDX_IRQ_ST, 33'h0);
    apb(1'b1, IDX_MASK, 8'h00);
    repeat (3) hit(3'h5, 3'b001, 2, 1'b0);
    hit(3'h5, 3'b001, 4, 1'b1);
    burst(3'h0, 3'b001, 4);
    repeat (2) @(posedge ref_clk);
    chk({sync_n, reinit}, 2'b01);
    apb(1'b1, IDX_LANE_HOLD + 6, 8'h02);
    burst(3'h6, 3'b110, 300);
    rd(IDX_ERR_CNT + {3'h6, 2'b01}, 33'hff);
    rd(IDX_ERR_CNT + {3'h6, 2'b10}, 33'h2c);
    rd(IDX_LANE_TERM + 6, 33'h0a);
    apb(1'b1, IDX_LANE_CTL + 6, 8'h3d);
    rd(IDX_ERR_CNT + {3'h6, 2'b01}, 33'h0);
    rxp[3] <= seed[15:8] | 8'h01;
    rd(IDX_IRQ_ST_MM, 33'h1);
    apb(1'b1, IDX_CFG_BASE + 3, rxp[3]);
    apb(1'b1, IDX_IRQ_ST_MM, 8'h01);
    rd(IDX_IRQ_ST_MM, 33'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
